/* logic/osc_cal_regs.svh */
// Purpose: Offsets, field positions, reset values and timing for osc_trim_calibrator
// Assumes: 32-bit AXI4-Lite register words, byte addresses
// Notes: Definitions only
`ifndef OSC_CAL_REGS_SVH
`define OSC_CAL_REGS_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_TRIM 8'h08
`define OFS_COUNT 8'h0C
`define OFS_IRQ_STAT 8'h10
`define OFS_IRQ_MASK 8'h14

// Field positions
`define CTRL_START_BIT 0
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_SRC_BIT 2
`define STAT_LIMIT_BIT 3
`define IRQ_DONE_BIT 0
`define IRQ_LIMIT_BIT 1
`define IRQ_STEP_BIT 2

// Reset values
`define TRIM_RST 8'h80
`define IRQ_MASK_RST 3'h0

// Event link source selections for the capture trigger
`define EVT_SEL_SUB 3'h0
`define EVT_SEL_EXT 3'h7

// Acceptance windows (sum of four intervals, or one low width)
`define SUB_SUM_LO 18'h00F3F
`define SUB_SUM_HI 18'h00F45
`define EXT_CNT_LO 18'h0F3E6
`define EXT_CNT_HI 18'h0F461
`define SUB_CAPTURES 3'h4

// Timing
`define MCLK_HZ 20000000
`define DEBOUNCE_MS 10
`define CHECK_HALF_LAST 3'h7

`endif

/* logic/osc_cal_pkg.sv */
// Purpose: Types shared by the calibrator files
// Assumes: Nothing beyond SystemVerilog
// Notes: Constants live in osc_cal_regs.svh
package osc_cal_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETTLE = 3'b001,
      ST_MEASURE = 3'b010,
      ST_EVAL = 3'b011,
      ST_DONE = 3'b100
   } cal_state_t;

   typedef enum logic {
      CAP_PERIOD = 1'b0,
      CAP_LOW_WIDTH = 1'b1
   } cap_mode_t;
endpackage : osc_cal_pkg

/* logic/cap_if.sv */
// Purpose: Link between the sequencer and the capture timer
// Assumes: Single clock domain
// Notes: ctl drives mode and restart, cap returns captured counts
`timescale 1ns/10ps
`default_nettype none
interface cap_if;
   osc_cal_pkg::cap_mode_t mode;
   logic restart;
   logic cap_valid;
   logic [15:0] cap_count;
   modport ctl (output mode, output restart, input cap_valid,
                input cap_count);
   modport cap (input mode, input restart, output cap_valid,
                output cap_count);
endinterface : cap_if
`default_nettype wire

/* logic/ref_capture.sv */
// Purpose: 16-bit capture timer counting the undivided clock between edges
// Assumes: ref_level synchronous to mclk
// Notes: First edge after restart only arms the timer
`timescale 1ns/10ps
`default_nettype none
module ref_capture (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ref_level,
   cap_if.cap bus
);
   logic prev_r, prev_nxt;
   logic armed_r, armed_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic valid_r, valid_nxt;
   logic [15:0] cap_r, cap_nxt;
   logic rise, fall;

   assign rise = ref_level && !prev_r;
   assign fall = !ref_level && prev_r;

   // Counter saturates so an absent reference cannot fake a short count
   always_comb begin
      prev_nxt = ref_level;
      armed_nxt = armed_r;
      valid_nxt = 1'b0;
      cap_nxt = cap_r;
      cnt_nxt = (cnt_r == 16'hFFFF) ? cnt_r : cnt_r + 16'h0001;
      if (bus.restart) begin
         armed_nxt = 1'b0;
      end else if (bus.mode == osc_cal_pkg::CAP_PERIOD) begin
         if (rise) begin
            valid_nxt = armed_r;
            cap_nxt = cnt_r;
            cnt_nxt = 16'h0001;
            armed_nxt = 1'b1;
         end
      end else begin
         if (fall) begin
            cnt_nxt = 16'h0001;
            armed_nxt = 1'b1;
         end else if (rise && armed_r) begin
            valid_nxt = 1'b1;
            cap_nxt = cnt_r;
            armed_nxt = 1'b0;
         end
      end
   end

   // Register stage
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         prev_r <= 1'b0;
         armed_r <= 1'b0;
         cnt_r <= 16'h0000;
         valid_r <= 1'b0;
         cap_r <= 16'h0000;
      end else begin
         prev_r <= prev_nxt;
         armed_r <= armed_nxt;
         cnt_r <= cnt_nxt;
         valid_r <= valid_nxt;
         cap_r <= cap_nxt;
      end
   end

   assign bus.cap_valid = valid_r;
   assign bus.cap_count = cap_r;
endmodule : ref_capture
`default_nettype wire

/* logic/osc_trim_calibrator.sv */
// Purpose: Oscillator trim calibrator with AXI4-Lite registers
// Assumes: mclk is the oscillator being trimmed; inputs synchronous to it
// Notes: Trim rises to speed the oscillator up
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`include "osc_cal_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module osc_trim_calibrator #(
   parameter int TRIM_W = 8,
   parameter int DEBOUNCE_CYC = `DEBOUNCE_MS * (`MCLK_HZ / 1000)
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic start_btn_n,
   input wire logic src_sel,
   input wire logic sub_ref_clock,
   input wire logic ext_ref_pin,
   output logic [TRIM_W-1:0] osc_trim_value,
   output logic check_clock_out,
   output logic cal_busy,
   output logic irq
);
   localparam int DB_W = $clog2(DEBOUNCE_CYC + 1);
   localparam logic [DB_W-1:0] DB_LAST = DB_W'(DEBOUNCE_CYC - 1);
   localparam logic [TRIM_W-1:0] TRIM_MAX = {TRIM_W{1'b1}};
   localparam logic [TRIM_W-1:0] TRIM_MIN = {TRIM_W{1'b0}};

   cap_if cap ();

   // Sequencer state
   osc_cal_pkg::cal_state_t state_r, state_nxt;
   logic [2:0] evt_sel_r, evt_sel_nxt;
   logic [2:0] ncap_r, ncap_nxt;
   logic [17:0] sum_r, sum_nxt;
   logic [17:0] last_r, last_nxt;
   logic [TRIM_W-1:0] trim_r, trim_nxt;
   logic done_r, done_nxt;
   logic limit_r, limit_nxt;
   logic restart_r, restart_nxt;
   logic busy_r, busy_nxt;
   // Start debounce and check clock
   logic btn_stable_r, btn_stable_nxt;
   logic [DB_W-1:0] db_cnt_r, db_cnt_nxt;
   logic [2:0] div_r, div_nxt;
   logic chk_r, chk_nxt;
   // Bus and interrupt state
   logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
   logic [7:0] waddr_r, waddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic wstrb0_r, wstrb0_nxt;
   logic awready_r, awready_nxt, wready_r, wready_nxt;
   logic bvalid_r, bvalid_nxt, arready_r, arready_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [2:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
   logic irq_r, irq_nxt;

   logic ext_mode, ref_level, btn_start, sw_start, do_write, ar_take;
   logic in_win, slow, fast, step_evt;
   logic [17:0] win_lo, win_hi;

   // Event link: selection 7 routes the external pin to the capture input
   assign ext_mode = (evt_sel_r == `EVT_SEL_EXT);
   assign ref_level = ext_mode ? ext_ref_pin : sub_ref_clock;
   assign cap.mode = ext_mode ? osc_cal_pkg::CAP_LOW_WIDTH
                              : osc_cal_pkg::CAP_PERIOD;
   assign cap.restart = restart_r;

   // Window per reference mode
   assign win_lo = ext_mode ? `EXT_CNT_LO : `SUB_SUM_LO;
   assign win_hi = ext_mode ? `EXT_CNT_HI : `SUB_SUM_HI;
   assign slow = (sum_r < win_lo);
   assign fast = (sum_r > win_hi);
   assign in_win = !slow && !fast;

   assign do_write = aw_held_r && w_held_r && !bvalid_r;
   assign ar_take = s_axi_arvalid && arready_r;
   assign sw_start = do_write && wstrb0_r && (waddr_r == `OFS_CTRL)
                     && wdata_r[`CTRL_START_BIT];

   ref_capture u_capture (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .ref_level(ref_level),
      .bus(cap)
   );

   // Debounce: level must hold for the full interval before it counts
   always_comb begin
      btn_stable_nxt = btn_stable_r;
      db_cnt_nxt = {DB_W{1'b0}};
      btn_start = 1'b0;
      if (start_btn_n != btn_stable_r) begin
         db_cnt_nxt = db_cnt_r + {{(DB_W-1){1'b0}}, 1'b1};
         if (db_cnt_r == DB_LAST) begin
            btn_stable_nxt = start_btn_n;
            db_cnt_nxt = {DB_W{1'b0}};
            btn_start = !start_btn_n;
         end
      end
   end

   // Check clock toggles every eight cycles, never gated
   always_comb begin
      div_nxt = div_r + 3'h1;
      chk_nxt = (div_r == `CHECK_HALF_LAST) ? !chk_r : chk_r;
   end

   // Calibration sequencer
   always_comb begin
      state_nxt = state_r;
      evt_sel_nxt = evt_sel_r;
      ncap_nxt = ncap_r;
      sum_nxt = sum_r;
      last_nxt = last_r;
      trim_nxt = trim_r;
      done_nxt = done_r;
      limit_nxt = limit_r;
      restart_nxt = 1'b0;
      step_evt = 1'b0;
      unique case (state_r)
         osc_cal_pkg::ST_IDLE, osc_cal_pkg::ST_DONE: begin
            if (do_write && wstrb0_r && waddr_r == `OFS_TRIM) begin
               trim_nxt = wdata_r[TRIM_W-1:0];
            end
            if (btn_start || sw_start) begin
               evt_sel_nxt = src_sel ? `EVT_SEL_EXT : `EVT_SEL_SUB;
               restart_nxt = 1'b1;
               done_nxt = 1'b0;
               limit_nxt = 1'b0;
               state_nxt = osc_cal_pkg::ST_SETTLE;
            end
         end
         osc_cal_pkg::ST_SETTLE: begin
            // Capture straddling a trim change is thrown away
            if (cap.cap_valid) begin
               ncap_nxt = 3'h0;
               sum_nxt = 18'h00000;
               state_nxt = osc_cal_pkg::ST_MEASURE;
            end
         end
         osc_cal_pkg::ST_MEASURE: begin
            if (cap.cap_valid) begin
               sum_nxt = sum_r + {2'b00, cap.cap_count};
               ncap_nxt = ncap_r + 3'h1;
               if (ext_mode || ncap_r == `SUB_CAPTURES - 3'h1) begin
                  state_nxt = osc_cal_pkg::ST_EVAL;
               end
            end
         end
         osc_cal_pkg::ST_EVAL: begin
            last_nxt = sum_r;
            if (in_win) begin
               done_nxt = 1'b1;
               state_nxt = osc_cal_pkg::ST_DONE;
            end else if ((slow && trim_r == TRIM_MAX)
                         || (fast && trim_r == TRIM_MIN)) begin
               limit_nxt = 1'b1;
               state_nxt = osc_cal_pkg::ST_DONE;
            end else begin
               trim_nxt = slow ? trim_r + 1'b1 : trim_r - 1'b1;
               step_evt = 1'b1;
               restart_nxt = 1'b1;
               state_nxt = osc_cal_pkg::ST_SETTLE;
            end
         end
         default: begin
            state_nxt = osc_cal_pkg::ST_IDLE;
         end
      endcase
      // Busy follows the next state so the flop matches the state change
      busy_nxt = (state_nxt != osc_cal_pkg::ST_IDLE)
                 && (state_nxt != osc_cal_pkg::ST_DONE);
   end

   // AXI4-Lite slave and interrupt status
   always_comb begin
      aw_held_nxt = aw_held_r;
      w_held_nxt = w_held_r;
      waddr_nxt = waddr_r;
      wdata_nxt = wdata_r;
      wstrb0_nxt = wstrb0_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      irq_mask_nxt = irq_mask_r;
      irq_stat_nxt = irq_stat_r;
      if (s_axi_awvalid && awready_r) begin
         aw_held_nxt = 1'b1;
         waddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
         w_held_nxt = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb0_nxt = s_axi_wstrb[0];
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (do_write) begin
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = 2'b00;
         unique case (waddr_r)
            `OFS_CTRL, `OFS_STATUS, `OFS_TRIM, `OFS_COUNT,
            `OFS_IRQ_STAT: begin
            end
            `OFS_IRQ_MASK: begin
               if (wstrb0_r) begin
                  irq_mask_nxt = wdata_r[2:0];
               end
            end
            default: begin
               bresp_nxt = 2'b10;
            end
         endcase
      end
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (ar_take) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = 2'b00;
         rdata_nxt = 32'h00000000;
         unique case (s_axi_araddr)
            `OFS_CTRL: begin
            end
            `OFS_STATUS: begin
               rdata_nxt[`STAT_BUSY_BIT] = cal_busy;
               rdata_nxt[`STAT_DONE_BIT] = done_r;
               rdata_nxt[`STAT_SRC_BIT] = ext_mode;
               rdata_nxt[`STAT_LIMIT_BIT] = limit_r;
            end
            `OFS_TRIM: rdata_nxt[TRIM_W-1:0] = trim_r;
            `OFS_COUNT: rdata_nxt[17:0] = last_r;
            `OFS_IRQ_STAT: begin
               rdata_nxt[2:0] = irq_stat_r;
               irq_stat_nxt = 3'h0;
            end
            `OFS_IRQ_MASK: rdata_nxt[2:0] = irq_mask_r;
            default: begin
               rresp_nxt = 2'b10;
            end
         endcase
      end
      // New events are applied after the read clear so they are not lost
      if (done_nxt && !done_r) begin
         irq_stat_nxt[`IRQ_DONE_BIT] = 1'b1;
      end
      if (limit_nxt && !limit_r) begin
         irq_stat_nxt[`IRQ_LIMIT_BIT] = 1'b1;
      end
      if (step_evt) begin
         irq_stat_nxt[`IRQ_STEP_BIT] = 1'b1;
      end
      irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
      awready_nxt = !aw_held_nxt && !bvalid_nxt;
      wready_nxt = !w_held_nxt && !bvalid_nxt;
      arready_nxt = !rvalid_nxt;
   end

   // All state registers
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= osc_cal_pkg::ST_IDLE;
         evt_sel_r <= `EVT_SEL_SUB;
         ncap_r <= 3'h0;
         sum_r <= 18'h00000;
         last_r <= 18'h00000;
         trim_r <= TRIM_W'(`TRIM_RST);
         done_r <= 1'b0;
         limit_r <= 1'b0;
         restart_r <= 1'b0;
         busy_r <= 1'b0;
         btn_stable_r <= 1'b1;
         db_cnt_r <= {DB_W{1'b0}};
         div_r <= 3'h0;
         chk_r <= 1'b0;
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         waddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
         wstrb0_r <= 1'b0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= 2'b00;
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rresp_r <= 2'b00;
         rdata_r <= 32'h00000000;
         irq_stat_r <= 3'h0;
         irq_mask_r <= `IRQ_MASK_RST;
         irq_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         evt_sel_r <= evt_sel_nxt;
         ncap_r <= ncap_nxt;
         sum_r <= sum_nxt;
         last_r <= last_nxt;
         trim_r <= trim_nxt;
         done_r <= done_nxt;
         limit_r <= limit_nxt;
         restart_r <= restart_nxt;
         busy_r <= busy_nxt;
         btn_stable_r <= btn_stable_nxt;
         db_cnt_r <= db_cnt_nxt;
         div_r <= div_nxt;
         chk_r <= chk_nxt;
         aw_held_r <= aw_held_nxt;
         w_held_r <= w_held_nxt;
         waddr_r <= waddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb0_r <= wstrb0_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_mask_r <= irq_mask_nxt;
         irq_r <= irq_nxt;
      end
   end

   // Every output comes straight from its own flop, so none can glitch
   assign cal_busy = busy_r;
   assign osc_trim_value = trim_r;
   assign check_clock_out = chk_r;
   assign irq = irq_r;
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;
endmodule : osc_trim_calibrator
`default_nettype wire

/* dv/osc_cal_props.sv */
// Purpose: Port-level checks for osc_trim_calibrator
// Assumes: One clock, mclk; sys_rst asynchronous, active high
// Notes: Bound from the bench top file
`timescale 1ns/10ps
`default_nettype none
module osc_cal_props #(
   parameter int TRIM_W = 8
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [TRIM_W-1:0] osc_trim_value,
   input wire logic check_clock_out,
   input wire logic cal_busy,
   input wire logic irq
);
   default clocking dc @(posedge mclk); endclocking
   default disable iff (sys_rst);

   // Check clock: eight cycles high, eight low, from reset onwards
   check_high_a: assert property (
      $rose(check_clock_out) |-> check_clock_out[*8] ##1 !check_clock_out)
      else $error("check clock high phase is not eight cycles");
   check_low_a: assert property (
      $fell(check_clock_out) |-> !check_clock_out[*8] ##1 check_clock_out)
      else $error("check clock low phase is not eight cycles");
   // While calibrating the trim only ever moves by a single step
   trim_step_a: assert property (
      cal_busy && $past(cal_busy) && $changed(osc_trim_value) |->
      osc_trim_value == $past(osc_trim_value) + 1'b1 ||
      osc_trim_value == $past(osc_trim_value) - 1'b1)
      else $error("trim moved by more than one step");
   // For four cycles after finishing the trim is left alone
   stop_after_done_a: assert property (
      $fell(cal_busy) |-> $stable(osc_trim_value)[*4])
      else $error("trim changed after calibration ended");
   // Bus handshakes follow the hand-over timing
   aw_drop_a: assert property (
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("awready stayed high after a take");
   b_answer_a: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid)
      else $error("write response late");
   r_answer_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   r_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   slverr_a: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14 |=>
      s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");

   // Main scenarios
   cal_end_c: cover property ($fell(cal_busy));
   irq_c: cover property ($rose(irq));
   refuse_c: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule : osc_cal_props
`default_nettype wire

/* dv/ref_src_model.sv */
// Purpose: Reference sources and start button beside the calibrator
// Assumes: mclk stands for the oscillator under trim
// Notes: Periods are in mclk cycles; the sub clock period follows the trim, the way a
//        faster oscillator fits more cycles into a fixed period
`timescale 1ns/10ps
`default_nettype none
module ref_src_model (
   input wire logic mclk,
   input wire logic [7:0] trim,
   input wire logic [15:0] sub_base,
   input wire logic [15:0] ext_low,
   input wire logic press,
   output logic sub_ref_clock,
   output logic ext_ref_pin,
   output logic start_btn_n
);
   int per;

   // Sub clock; period re-read once per cycle so a trim step shows late
   initial begin
      sub_ref_clock = 1'b0;
      @(posedge mclk);
      forever begin
         per = int'(sub_base) + int'(trim) - 128;
         sub_ref_clock <= 1'b1;
         repeat (per / 2) @(posedge mclk);
         sub_ref_clock <= 1'b0;
         repeat (per - per / 2) @(posedge mclk);
      end
   end

   // External square wave with equal halves
   initial begin
      ext_ref_pin = 1'b1;
      @(posedge mclk);
      forever begin
         repeat (ext_low) @(posedge mclk);
         ext_ref_pin <= ~ext_ref_pin;
      end
   end

   // Contact chatter: six fast toggles after each change of the press
   initial begin
      start_btn_n = 1'b1;
      forever begin
         @(press);
         repeat (6) begin
            @(posedge mclk);
            start_btn_n <= ~start_btn_n;
         end
         @(posedge mclk);
         start_btn_n <= ~press;
      end
   end
endmodule : ref_src_model
`default_nettype wire

/* dv/osc_trim_calibrator_tb.sv */
// Purpose: Self-checking bench for osc_trim_calibrator
// Assumes: Debounce shortened to 20 cycles
// Notes: Expected trims follow from the model's period law
`include "osc_cal_regs.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin \
   compares++; \
   if ((got) !== (ex)) begin \
      fails++; \
      $display("[ERR] %s exp %0h got %0h", nm, ex, got); \
   end \
end
module osc_trim_calibrator_tb;
   localparam int DEB = 20;
   localparam int LIMIT = 80000;
   logic mclk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, start_btn_n, src_sel;
   logic sub_ref_clock, ext_ref_pin, check_clock_out, cal_busy, irq, press;
   logic [7:0] s_axi_awaddr, s_axi_araddr, osc_trim_value;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] sub_base, ext_low;
   int fails = 0;
   int compares = 0;
   int cycles = 0;

   osc_trim_calibrator #(.TRIM_W(8), .DEBOUNCE_CYC(DEB)) i_dut (
      .mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .start_btn_n(start_btn_n), .src_sel(src_sel),
      .sub_ref_clock(sub_ref_clock), .ext_ref_pin(ext_ref_pin),
      .osc_trim_value(osc_trim_value), .check_clock_out(check_clock_out),
      .cal_busy(cal_busy), .irq(irq));

   ref_src_model i_src (.mclk(mclk), .trim(osc_trim_value),
      .sub_base(sub_base), .ext_low(ext_low), .press(press),
      .sub_ref_clock(sub_ref_clock), .ext_ref_pin(ext_ref_pin),
      .start_btn_n(start_btn_n));

   // 20 MHz clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // Hang guard sized for three calibrations
   always @(posedge mclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         fails++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      if (fails == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test

   // Write: address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      forever begin
         @(posedge mclk);
         if (s_axi_bvalid) break;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      `CHK("bresp", (a > 8'h14) ? 2'b10 : 2'b00, s_axi_bresp)
   endtask : axi_wr

   // Read: rready comes one cycle late so the slave must hold its data
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      forever begin
         @(posedge mclk);
         if (s_axi_rvalid && s_axi_rready) break;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         else if (!s_axi_arvalid) s_axi_rready <= 1'b1;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_rd

   // Trim at which four periods first land in 3903..3909
   function automatic int exp_trim(input int d);
      if (d < 0) return 128 - d;
      if (d > 1) return 129 - d;
      return 128;
   endfunction : exp_trim

   function automatic int exp_per(input int d);
      return 976 + d + exp_trim(d) - 128;
   endfunction : exp_per

   // One sub clock calibration; d offsets the period at trim 0x80
   task automatic sub_run(input int d, input logic btn);
      int n;
      logic [31:0] v;
      logic [1:0] r;
      n = 0;
      sub_base <= 16'(976 + d);
      repeat (1000) @(posedge mclk);
      if (btn) press <= 1'b1;
      else axi_wr(`OFS_CTRL, 32'h1);
      while (!cal_busy) begin
         @(posedge mclk);
         n++;
      end
      if (btn) `CHK("debounce", 1'b1, n >= DEB)
      src_sel <= 1'b1;
      axi_wr(`OFS_TRIM, 32'h10);
      while (cal_busy) @(posedge mclk);
      press <= 1'b0;
      src_sel <= 1'b0;
      axi_rd(`OFS_TRIM, v, r);
      `CHK("trim", 32'(exp_trim(d)), v)
      axi_rd(`OFS_STATUS, v, r);
      `CHK("status", 32'h2, v)
      axi_rd(`OFS_COUNT, v, r);
      `CHK("sum", 32'(4 * exp_per(d)), v)
      `CHK("irq", 1'b1, irq)
      axi_rd(`OFS_IRQ_STAT, v, r);
      `CHK("irq stat", (d inside {0, 1}) ? 32'h1 : 32'h5, v)
      repeat (40) @(posedge mclk);
      `CHK("irq cleared", 1'b0, irq)
   endtask : sub_run

   initial begin
      logic [31:0] v;
      logic [1:0] r;
      sys_rst = 1'b1;
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b1;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      src_sel = 1'b0;
      press = 1'b0;
      sub_base = 16'h03D0;
      ext_low = 16'h012C;
      void'($urandom(59923));
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      axi_rd(`OFS_TRIM, v, r);
      `CHK("trim reset", 32'h80, v)
      axi_rd(`OFS_IRQ_MASK, v, r);
      `CHK("mask reset", 32'h0, v)
      axi_rd(8'h18, v, r);
      `CHK("unmapped", 34'h200000000, {r, v})
      axi_wr(`OFS_IRQ_MASK, 32'h7);
      // Byte 0 strobe low: the write must leave the mask alone
      s_axi_wstrb <= 4'hE;
      axi_wr(`OFS_IRQ_MASK, 32'h0);
      s_axi_wstrb <= 4'hF;
      axi_rd(`OFS_IRQ_MASK, v, r);
      `CHK("strobe", 32'h7, v)
      axi_wr(8'h18, 32'h0);
      // Slow by button, then fast by a random amount by register
      sub_run(-2, 1'b1);
      sub_run(2 + int'($urandom % 3), 1'b0);
      // Far too few cycles in the low half: climbs and stops at the top
      axi_wr(`OFS_IRQ_MASK, 32'h1);
      axi_wr(`OFS_TRIM, 32'hFE);
      src_sel <= 1'b1;
      axi_wr(`OFS_CTRL, 32'h1);
      while (!cal_busy) @(posedge mclk);
      while (cal_busy) @(posedge mclk);
      axi_rd(`OFS_TRIM, v, r);
      `CHK("trim top", 32'hFF, v)
      axi_rd(`OFS_STATUS, v, r);
      `CHK("ext status", 32'hC, v)
      axi_rd(`OFS_COUNT, v, r);
      `CHK("low width", 32'h12C, v)
      `CHK("masked irq", 1'b0, irq)
      axi_rd(`OFS_IRQ_STAT, v, r);
      `CHK("ext irq stat", 32'h6, v)
      end_of_test();
   end
endmodule : osc_trim_calibrator_tb

bind osc_trim_calibrator osc_cal_props #(.TRIM_W(TRIM_W)) i_props (
   .mclk(mclk), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .osc_trim_value(osc_trim_value),
   .check_clock_out(check_clock_out), .cal_busy(cal_busy), .irq(irq));
`default_nettype wire
